// file: design/spss_defines.svh
`ifndef SPSS_DEFINES_SVH
`define SPSS_DEFINES_SVH

// register byte offsets
`define SPSS_OFF_CTRL 12'h000
`define SPSS_OFF_CMD 12'h004
`define SPSS_OFF_STATUS 12'h008
`define SPSS_OFF_THROTTLE 12'h00C
`define SPSS_OFF_LVL2 12'h010
`define SPSS_OFF_LVL3 12'h014
`define SPSS_OFF_LVL4 12'h018
`define SPSS_OFF_PMCON3 12'h01C

// control register fields
`define SPSS_CTRL_THR_EN 0
`define SPSS_CTRL_ARBITER_DISABLE 1
`define SPSS_CTRL_REDIRECT 2
`define SPSS_CTRL_DEEPER 3
`define SPSS_CTRL_BREAK_EN 4
`define SPSS_CTRL_WIDTH 5

// command register: sleep type codes
`define SPSS_SLP_S1 3'h1
`define SPSS_SLP_S3 3'h3
`define SPSS_SLP_S4 3'h4
`define SPSS_SLP_S5 3'h5
`define SPSS_CMD_SLEEP_BIT 3

// power management config three: after power loss select
`define SPSS_PMCON3_AFTER 0

// throttle field: duty counts in 4-bit period
`define SPSS_THR_RESET 4'h8
`define SPSS_THR_PERIOD 16

// voltage settle time in ns and derived cycles
`define SPSS_VOLT_NS 2000
`define SPSS_CLK_NS 20
`define SPSS_VOLT_CYC ((`SPSS_VOLT_NS + `SPSS_CLK_NS - 1) / `SPSS_CLK_NS)

// bus answers
`define SPSS_RESP_OKAY 2'h0
`define SPSS_RESP_SLVERR 2'h2

`endif

// file: design/spss_pkg.sv
package spss_pkg;
    typedef enum logic [3:0] {
        ST_C0, ST_C1, ST_C2_REQ, ST_C2, ST_C3_REQ, ST_C3_STOP, ST_C3, ST_C4_VDOWN, ST_C4,
        ST_C4_VUP, ST_EXIT_CLK, ST_SLEEP, ST_S5, ST_G3
    } spss_state_t;

    typedef enum logic [2:0] {
        SL_NONE, SL_S1, SL_S3, SL_S4, SL_S5
    } spss_sleep_t;
endpackage

// file: design/spss_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser; value changes only when stages two and three agree
module spss_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] out_d;

    genvar i;
    // per-bit agreement filter
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
            end
        end
    endgenerate

    // stage registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            out_q <= INIT;
        end else begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;
endmodule
`default_nettype wire

// file: design/spss_sequencer.sv
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "spss_defines.svh"
module spss_sequencer #(
    parameter int VOLT_CYCLES = `SPSS_VOLT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic thermal_alarm_in_n,
    input wire logic battery_low_in_n,
    input wire logic cpuHaltIn,
    input wire logic stopGrantIn,
    input wire logic breakEventIn,
    input wire logic wakeEventIn,
    input wire logic powerButtonOverrideIn,
    input wire logic powerFailIn,
    output logic cpu_stop_request_n,
    output logic cpu_clock_halt_n,
    output logic cpuVoltageLow,
    output logic memGrantBlock,
    output logic sysClockStop,
    output logic memRefreshKeep,
    output logic [2:0] sleepLevel
);
    localparam int VW = $clog2(VOLT_CYCLES + 1);
    localparam logic [VW-1:0] VLOAD = VW'(VOLT_CYCLES);
    localparam logic [3:0] THR_LAST = 4'(`SPSS_THR_PERIOD - 1);
    // enum order to command code
    localparam logic [2:0] SLP_CODE [8] = '{3'h0, `SPSS_SLP_S1, `SPSS_SLP_S3, `SPSS_SLP_S4, `SPSS_SLP_S5,
        3'h0, 3'h0, 3'h0};

    // pin inputs pass the three-stage synchroniser
    logic [7:0] pinSync;
    spss_sync #(.WIDTH(8), .INIT(8'h03)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .asyncIn({powerFailIn, powerButtonOverrideIn, wakeEventIn, breakEventIn, stopGrantIn, cpuHaltIn,
            battery_low_in_n, thermal_alarm_in_n}),
        .syncOut(pinSync)
    );
    logic thermN, batLowN, halt, grant, brk, wake, pbo, pfail;
    assign {pfail, pbo, wake, brk, grant, halt, batLowN, thermN} = pinSync;

    // register state
    logic [`SPSS_CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
    logic [3:0] thrDuty_q, thrDuty_d;
    logic afterSel_q, afterSel_d;
    logic awHave_q, awHave_d, wHave_q, wHave_d, bValid_q, bValid_d, rValid_q, rValid_d;
    logic [11:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rData_q, rData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
    logic lvl2Rd, lvl3Rd, lvl4Rd, sleepWr;
    logic [2:0] sleepCode;

    // sequencer state
    spss_pkg::spss_state_t state_q, state_d;
    spss_pkg::spss_state_t preLoss_q, preLoss_d;
    spss_pkg::spss_sleep_t sleepSel_q, sleepSel_d;
    logic lvl4Pend_q, lvl4Pend_d;
    logic [VW-1:0] vcnt_q, vcnt_d;
    logic [3:0] thrCnt_q, thrCnt_d;
    logic stopReq_q, stopReq_d, clkHalt_q, clkHalt_d, vLow_q, vLow_d;
    logic fromC1_q, fromC1_d;

    // bus: write channels taken in any order, response after both
    always_comb begin
        awHave_d = awHave_q;
        wHave_d = wHave_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        ctrl_d = ctrl_q;
        thrDuty_d = thrDuty_q;
        afterSel_d = afterSel_q;
        sleepWr = 1'b0;
        sleepCode = wData_q[2:0];
        if (s_axi_awvalid && s_axi_awready) begin
            awHave_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHave_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
        if (awHave_q && wHave_q && !bValid_q) begin
            awHave_d = 1'b0;
            wHave_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = `SPSS_RESP_OKAY;
            case (awAddr_q)
                `SPSS_OFF_CTRL: begin
                    if (wStrb_q[0]) begin
                        ctrl_d = wData_q[`SPSS_CTRL_WIDTH-1:0];
                    end
                end
                `SPSS_OFF_CMD: begin
                    sleepWr = wStrb_q[0] && wData_q[`SPSS_CMD_SLEEP_BIT];
                end
                `SPSS_OFF_THROTTLE: begin
                    if (wStrb_q[0]) begin
                        thrDuty_d = wData_q[3:0];
                    end
                end
                `SPSS_OFF_PMCON3: begin
                    if (wStrb_q[0]) begin
                        afterSel_d = wData_q[`SPSS_PMCON3_AFTER];
                    end
                end
                `SPSS_OFF_STATUS, `SPSS_OFF_LVL2, `SPSS_OFF_LVL3, `SPSS_OFF_LVL4: begin
                    bResp_d = `SPSS_RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    bResp_d = `SPSS_RESP_SLVERR;
                end
            endcase
        end
    end

    // bus: read path, level reads double as idle entry strobes
    always_comb begin
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        lvl2Rd = 1'b0;
        lvl3Rd = 1'b0;
        lvl4Rd = 1'b0;
        if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_d = 1'b1;
            rResp_d = `SPSS_RESP_OKAY;
            rData_d = 32'h0000_0000;
            case (s_axi_araddr)
                `SPSS_OFF_CTRL: rData_d = 32'(ctrl_q);
                `SPSS_OFF_STATUS: rData_d = {16'h0000, 5'h00, sleepLevel, state_q, stopReq_q, clkHalt_q,
                    vLow_q, batLowN};
                `SPSS_OFF_THROTTLE: rData_d = 32'(thrDuty_q);
                `SPSS_OFF_PMCON3: rData_d = 32'(afterSel_q);
                `SPSS_OFF_CMD: rData_d = 32'h0000_0000;
                `SPSS_OFF_LVL2: lvl2Rd = 1'b1;
                `SPSS_OFF_LVL3: lvl3Rd = 1'b1;
                `SPSS_OFF_LVL4: lvl4Rd = 1'b1;
                default: rResp_d = `SPSS_RESP_SLVERR;
            endcase
        end
    end

    assign s_axi_awready = !awHave_q;
    assign s_axi_wready = !wHave_q;
    assign s_axi_arready = !rValid_q;

    // power state walk
    always_comb begin
        state_d = state_q;
        preLoss_d = preLoss_q;
        sleepSel_d = sleepSel_q;
        vcnt_d = (vcnt_q != '0) ? vcnt_q - VW'(1) : vcnt_q;
        thrCnt_d = thrCnt_q + 4'h1;
        stopReq_d = stopReq_q;
        clkHalt_d = clkHalt_q;
        vLow_d = vLow_q;
        fromC1_d = fromC1_q;
        if (sleepWr) begin
            case (sleepCode)
                `SPSS_SLP_S1: sleepSel_d = spss_pkg::SL_S1;
                `SPSS_SLP_S3: sleepSel_d = spss_pkg::SL_S3;
                `SPSS_SLP_S4: sleepSel_d = spss_pkg::SL_S4;
                `SPSS_SLP_S5: sleepSel_d = spss_pkg::SL_S5;
                default: sleepSel_d = spss_pkg::SL_NONE;
            endcase
        end
        if (pfail && state_q != spss_pkg::ST_G3) begin
            preLoss_d = state_q;
            state_d = spss_pkg::ST_G3;
            stopReq_d = 1'b0;
            clkHalt_d = 1'b0;
            vLow_d = 1'b0;
        end else if (pbo && state_q != spss_pkg::ST_G3 && state_q != spss_pkg::ST_S5) begin
            state_d = spss_pkg::ST_S5;
            stopReq_d = 1'b0;
            clkHalt_d = 1'b0;
            vLow_d = 1'b0;
        end else begin
            case (state_q)
                spss_pkg::ST_C0: begin
                    stopReq_d = (ctrl_q[`SPSS_CTRL_THR_EN] || !thermN) && (thrCnt_q < thrDuty_q);
                    if (thrCnt_q == THR_LAST) begin
                        thrCnt_d = 4'h0;
                    end
                    fromC1_d = 1'b0;
                    if (sleepSel_q != spss_pkg::SL_NONE) begin
                        state_d = spss_pkg::ST_C2_REQ;
                        stopReq_d = 1'b1;
                    end else if (lvl2Rd) begin
                        state_d = spss_pkg::ST_C2_REQ;
                        stopReq_d = 1'b1;
                    end else if (lvl3Rd || lvl4Rd) begin
                        state_d = spss_pkg::ST_C3_REQ;
                        stopReq_d = 1'b1;
                    end else if (halt) begin
                        state_d = spss_pkg::ST_C1;
                        stopReq_d = 1'b0;
                    end
                end
                spss_pkg::ST_C1: begin
                    fromC1_d = 1'b1;
                    if (brk || !halt) begin
                        state_d = spss_pkg::ST_C0;
                    end else if (lvl2Rd || sleepSel_q != spss_pkg::SL_NONE) begin
                        state_d = spss_pkg::ST_C2_REQ;
                        stopReq_d = 1'b1;
                    end
                end
                spss_pkg::ST_C2_REQ: begin
                    if (grant) begin
                        state_d = (sleepSel_q != spss_pkg::SL_NONE) ? spss_pkg::ST_C3_STOP : spss_pkg::ST_C2;
                    end
                end
                spss_pkg::ST_C2: begin
                    if (brk && ctrl_q[`SPSS_CTRL_BREAK_EN]) begin
                        stopReq_d = 1'b0;
                        state_d = fromC1_q ? spss_pkg::ST_C1 : spss_pkg::ST_C0;
                    end
                end
                spss_pkg::ST_C3_REQ: begin
                    if (grant) begin
                        state_d = spss_pkg::ST_C3_STOP;
                    end
                end
                spss_pkg::ST_C3_STOP: begin
                    clkHalt_d = 1'b1;
                    vcnt_d = VLOAD;
                    if (sleepSel_q != spss_pkg::SL_NONE) begin
                        state_d = spss_pkg::ST_SLEEP;
                    end else if (lvl4Pend_q || ctrl_q[`SPSS_CTRL_REDIRECT]) begin
                        state_d = spss_pkg::ST_C4_VDOWN;
                    end else begin
                        state_d = spss_pkg::ST_C3;
                    end
                end
                spss_pkg::ST_C3: begin
                    if (brk && ctrl_q[`SPSS_CTRL_BREAK_EN]) begin
                        state_d = spss_pkg::ST_EXIT_CLK;
                    end
                end
                spss_pkg::ST_C4_VDOWN: begin
                    vLow_d = 1'b1;
                    if (vcnt_q == '0) begin
                        state_d = spss_pkg::ST_C4;
                    end
                end
                spss_pkg::ST_C4: begin
                    if (brk && ctrl_q[`SPSS_CTRL_BREAK_EN]) begin
                        vLow_d = 1'b0;
                        vcnt_d = VLOAD;
                        state_d = spss_pkg::ST_C4_VUP;
                    end
                end
                spss_pkg::ST_C4_VUP: begin
                    if (vcnt_q == '0) begin
                        state_d = spss_pkg::ST_EXIT_CLK;
                    end
                end
                spss_pkg::ST_EXIT_CLK: begin
                    if (clkHalt_q) begin
                        clkHalt_d = 1'b0;
                    end else begin
                        stopReq_d = 1'b0;
                        state_d = fromC1_q ? spss_pkg::ST_C1 : spss_pkg::ST_C0;
                    end
                end
                spss_pkg::ST_SLEEP: begin
                    vLow_d = (sleepSel_q == spss_pkg::SL_S1) && ctrl_q[`SPSS_CTRL_DEEPER];
                    if (sleepSel_q == spss_pkg::SL_S5) begin
                        state_d = spss_pkg::ST_S5;
                    end else if (wake && batLowN) begin
                        sleepSel_d = spss_pkg::SL_NONE;
                        fromC1_d = 1'b0;
                        if (vLow_q) begin
                            vLow_d = 1'b0;
                            vcnt_d = VLOAD;
                            state_d = spss_pkg::ST_C4_VUP;
                        end else begin
                            state_d = spss_pkg::ST_EXIT_CLK;
                        end
                    end
                end
                spss_pkg::ST_S5: begin
                    sleepSel_d = spss_pkg::SL_NONE;
                    stopReq_d = 1'b0;
                    clkHalt_d = 1'b0;
                    vLow_d = 1'b0;
                    if (wake && batLowN) begin
                        state_d = spss_pkg::ST_C0;
                    end
                end
                spss_pkg::ST_G3: begin
                    sleepSel_d = spss_pkg::SL_NONE;
                    if (!pfail && batLowN) begin
                        state_d = (afterSel_q || preLoss_q == spss_pkg::ST_S5 || preLoss_q == spss_pkg::ST_SLEEP) ?
                            spss_pkg::ST_S5 : spss_pkg::ST_C0;
                    end
                end
                default: state_d = spss_pkg::ST_C0;
            endcase
        end
    end

    // level 4 read held until clock halt
    always_comb begin
        lvl4Pend_d = lvl4Pend_q;
        if (state_q == spss_pkg::ST_C0 && lvl4Rd) begin
            lvl4Pend_d = 1'b1;
        end else if (state_q == spss_pkg::ST_C3_STOP) begin
            lvl4Pend_d = 1'b0;
        end
    end

    // all registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= '0;
            thrDuty_q <= `SPSS_THR_RESET;
            afterSel_q <= 1'b0;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            bValid_q <= 1'b0;
            rValid_q <= 1'b0;
            awAddr_q <= 12'h000;
            wData_q <= 32'h0000_0000;
            rData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bResp_q <= `SPSS_RESP_OKAY;
            rResp_q <= `SPSS_RESP_OKAY;
            state_q <= spss_pkg::ST_C0;
            preLoss_q <= spss_pkg::ST_C0;
            sleepSel_q <= spss_pkg::SL_NONE;
            vcnt_q <= '0;
            thrCnt_q <= 4'h0;
            stopReq_q <= 1'b0;
            clkHalt_q <= 1'b0;
            vLow_q <= 1'b0;
            fromC1_q <= 1'b0;
            lvl4Pend_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            thrDuty_q <= thrDuty_d;
            afterSel_q <= afterSel_d;
            awHave_q <= awHave_d;
            wHave_q <= wHave_d;
            bValid_q <= bValid_d;
            rValid_q <= rValid_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            rData_q <= rData_d;
            wStrb_q <= wStrb_d;
            bResp_q <= bResp_d;
            rResp_q <= rResp_d;
            state_q <= state_d;
            preLoss_q <= preLoss_d;
            sleepSel_q <= sleepSel_d;
            vcnt_q <= vcnt_d;
            thrCnt_q <= thrCnt_d;
            stopReq_q <= stopReq_d;
            clkHalt_q <= clkHalt_d;
            vLow_q <= vLow_d;
            fromC1_q <= fromC1_d;
            lvl4Pend_q <= lvl4Pend_d;
        end
    end

    // outputs from flops or state decode
    assign cpu_stop_request_n = !stopReq_q;
    assign cpu_clock_halt_n = !clkHalt_q;
    assign cpuVoltageLow = vLow_q;
    assign memGrantBlock = ctrl_q[`SPSS_CTRL_ARBITER_DISABLE] || clkHalt_q;
    assign sysClockStop = (state_q == spss_pkg::ST_SLEEP) || (state_q == spss_pkg::ST_S5) || (state_q == spss_pkg::ST_G3);
    assign memRefreshKeep = (state_q == spss_pkg::ST_SLEEP) &&
        (sleepSel_q == spss_pkg::SL_S1 || sleepSel_q == spss_pkg::SL_S3);
    assign sleepLevel = (state_q == spss_pkg::ST_SLEEP) ? SLP_CODE[sleepSel_q] : 3'h0;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
endmodule
`default_nettype wire

// file: bench/spss_sequencer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// pin checks, one clock domain
module spss_sequencer_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cpu_stop_request_n,
    input wire logic cpu_clock_halt_n,
    input wire logic cpuVoltageLow,
    input wire logic memGrantBlock,
    input wire logic sysClockStop,
    input wire logic memRefreshKeep,
    input wire logic [2:0] sleepLevel,
    input wire logic powerFailIn,
    input wire logic powerButtonOverrideIn
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // exit steps seen on the pins
    sequence clkRelease;
        $rose(cpu_clock_halt_n);
    endsequence
    sequence reqRelease;
        $rose(cpu_stop_request_n);
    endsequence
    // inputs must stand through the synchroniser
    sequence failHeld;
        $rose(powerFailIn) ##1 powerFailIn [*5];
    endsequence
    sequence overrideHeld;
        $rose(powerButtonOverrideIn) ##1 powerButtonOverrideIn [*5];
    endsequence
    haltNeedsReq_a: assert property (!cpu_clock_halt_n |-> !cpu_stop_request_n)
        else $error("halt without request");
    haltAfterReq_a: assert property ($fell(cpu_clock_halt_n) |-> $past(cpu_stop_request_n) == 1'h0)
        else $error("halt before request");
    voltAfterHalt_a: assert property ($rose(cpuVoltageLow) |-> !cpu_clock_halt_n)
        else $error("voltage low before halt");
    voltUpFirst_a: assert property (clkRelease |-> !cpuVoltageLow)
        else $error("clock released at low voltage");
    reqLast_a: assert property (reqRelease |-> cpu_clock_halt_n)
        else $error("request released first");
    masterBlock_a: assert property (!cpu_clock_halt_n |-> memGrantBlock)
        else $error("masters not blocked");
    sleepClock_a: assert property (sleepLevel != 3'h0 |-> sysClockStop)
        else $error("clocks running in sleep");
    ramRefresh_a: assert property (sleepLevel == 3'h3 |-> memRefreshKeep)
        else $error("refresh stopped");
    failOff_a: assert property (failHeld |-> ##[0:4] sysClockStop)
        else $error("failure left clocks on");
    overrideOff_a: assert property (overrideHeld |-> ##[0:4] sysClockStop)
        else $error("override did not reach soft off");
endmodule
bind spss_sequencer spss_sequencer_asserts i_spss_sequencer_asserts (.clk, .rstn,
    .cpu_stop_request_n, .cpu_clock_halt_n, .cpuVoltageLow, .memGrantBlock, .sysClockStop, .memRefreshKeep,
    .sleepLevel, .powerFailIn, .powerButtonOverrideIn);
`default_nettype wire

// file: bench/spss_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// processor stand-in: grants stop after a short or long delay
module spss_cpu_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cpu_stop_request_n,
    input wire logic slow,
    output logic stopGrantIn
);
    logic [3:0] cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            stopGrantIn <= 1'h0;
        end else if (cpu_stop_request_n) begin
            cnt <= 4'h0;
            stopGrantIn <= 1'h0;
        end else if (cnt != (slow ? 4'hC : 4'h2)) begin
            cnt <= cnt + 4'h1;
        end else begin
            stopGrantIn <= 1'h1;
        end
    end
endmodule
`default_nettype wire

// file: bench/test_system_power_state_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "spss_defines.svh"
module test_system_power_state_sequencer;
    logic clk = 1'h0, rstn = 1'h0, slow = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h8F6DD21F, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stopGrantIn;
    logic thermal_alarm_in_n = 1'h1, battery_low_in_n = 1'h1, cpuHaltIn = 1'h0, breakEventIn = 1'h0;
    logic wakeEventIn = 1'h0, powerButtonOverrideIn = 1'h0, powerFailIn = 1'h0;
    logic cpu_stop_request_n, cpu_clock_halt_n, cpuVoltageLow, memGrantBlock, sysClockStop, memRefreshKeep;
    logic [2:0] sleepLevel;
    logic [2:0] ty [4] = '{`SPSS_SLP_S1, `SPSS_SLP_S3, `SPSS_SLP_S4, `SPSS_SLP_S5};
    int nErrors = 0, checksDone = 0, k;
    always #10 clk = ~clk;
    // short voltage settle
    spss_sequencer #(.VOLT_CYCLES(3)) i_spss_sequencer (.*);
    spss_cpu_model i_spss_cpu_model (.*);
    function logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic sig(input int s);
        case (s)
            0: sig = cpu_stop_request_n;
            1: sig = cpu_clock_halt_n;
            2: sig = cpuVoltageLow;
            default: sig = sysClockStop;
        endcase
    endfunction
    task finish_test;
        if (nErrors == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checksDone++;
        if (g !== e) begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // bounded wait for a pin level
    task waitc(input int s, input logic v);
        for (int i = 0; i < 400 && sig(s) !== v; i++) @(posedge clk);
        chk({31'h0, sig(s)}, {31'h0, v});
        if (sig(s) !== v)
            finish_test();
    endtask
    // write: address and data together, each dropped once taken
    task wr(input logic [11:0] a, input logic [31:0] v);
        int i;
        i = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
            i++;
        end while (!s_axi_bvalid && i < 200);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (!s_axi_bvalid) begin
            nErrors++;
            finish_test();
        end
    endtask
    task rd(input logic [11:0] a, output logic [31:0] v);
        int i;
        i = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
            i++;
        end while (!s_axi_rvalid && i < 200);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (!s_axi_rvalid) begin
            nErrors++;
            finish_test();
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        repeat (6) @(posedge clk);
        rd(`SPSS_OFF_THROTTLE, d);
        chk(d, {28'h0, `SPSS_THR_RESET});
        rd(12'h020, d);
        chk({30'h0, resp}, {30'h0, `SPSS_RESP_SLVERR});
        wr(12'h024, 32'h1);
        chk({30'h0, resp}, {30'h0, `SPSS_RESP_SLVERR});
        // random control and duty readback
        repeat (4) begin
            rnd = lfsr(rnd);
            wr(`SPSS_OFF_CTRL, rnd);
            rd(`SPSS_OFF_CTRL, d);
            chk(d, rnd & 32'h1F);
            wr(`SPSS_OFF_THROTTLE, rnd);
            rd(`SPSS_OFF_THROTTLE, d);
            chk(d, rnd & 32'hF);
        end
        wr(`SPSS_OFF_THROTTLE, 32'h4);
        wr(`SPSS_OFF_CTRL, 32'h1 << `SPSS_CTRL_THR_EN);
        waitc(0, 1'h0);
        waitc(0, 1'h1);
        wr(`SPSS_OFF_CTRL, 32'h0);
        thermal_alarm_in_n <= 1'h0;
        waitc(0, 1'h0);
        waitc(0, 1'h1);
        thermal_alarm_in_n <= 1'h1;
        repeat (40) @(posedge clk);
        // idle levels 2, 3, 4 and redirected 3, left by break
        for (k = 0; k < 4; k++) begin
            slow <= k[0];
            wr(`SPSS_OFF_CTRL, (32'h1 << `SPSS_CTRL_BREAK_EN) | (k > 0 ? 32'h1 << `SPSS_CTRL_ARBITER_DISABLE : 32'h0)
                | (k == 3 ? 32'h1 << `SPSS_CTRL_REDIRECT : 32'h0));
            rd(k == 0 ? `SPSS_OFF_LVL2 : (k == 2 ? `SPSS_OFF_LVL4 : `SPSS_OFF_LVL3), d);
            waitc(0, 1'h0);
            repeat (20) @(posedge clk);
            chk({31'h0, cpu_clock_halt_n}, {31'h0, k == 0});
            chk({31'h0, cpuVoltageLow}, {31'h0, k > 1});
            chk({31'h0, memGrantBlock}, {31'h0, k > 0});
            breakEventIn <= 1'h1;
            waitc(0, 1'h1);
            breakEventIn <= 1'h0;
            chk({30'h0, cpuVoltageLow, cpu_clock_halt_n}, 32'h1);
        end
        cpuHaltIn <= 1'h1;
        repeat (10) @(posedge clk);
        rd(`SPSS_OFF_STATUS, d);
        chk((d >> 4) & 32'hF, 32'(spss_pkg::ST_C1));
        cpuHaltIn <= 1'h0;
        repeat (10) @(posedge clk);
        // every sleep type, wake held off by low battery
        wr(`SPSS_OFF_CTRL, (32'h1 << `SPSS_CTRL_BREAK_EN) | (32'h1 << `SPSS_CTRL_DEEPER));
        for (k = 0; k < 4; k++) begin
            wr(`SPSS_OFF_CMD, (32'h1 << `SPSS_CMD_SLEEP_BIT) | ty[k]);
            waitc(3, 1'h1);
            if (k < 3)
                chk({29'h0, sleepLevel}, {29'h0, ty[k]});
            chk({31'h0, memRefreshKeep}, {31'h0, k < 2});
            if (k == 0)
                waitc(2, 1'h1);
            battery_low_in_n <= 1'h0;
            wakeEventIn <= 1'h1;
            repeat (30) @(posedge clk);
            chk({31'h0, sysClockStop}, 32'h1);
            battery_low_in_n <= 1'h1;
            waitc(3, 1'h0);
            wakeEventIn <= 1'h0;
            waitc(0, 1'h1);
        end
        // power return with select set, then clear
        for (k = 1; k >= 0; k--) begin
            wr(`SPSS_OFF_PMCON3, k);
            powerFailIn <= 1'h1;
            waitc(3, 1'h1);
            powerFailIn <= 1'h0;
            repeat (30) @(posedge clk);
            chk({31'h0, sysClockStop}, {31'h0, k == 1});
            wakeEventIn <= 1'h1;
            waitc(3, 1'h0);
            wakeEventIn <= 1'h0;
        end
        powerButtonOverrideIn <= 1'h1;
        waitc(3, 1'h1);
        powerButtonOverrideIn <= 1'h0;
        rd(`SPSS_OFF_STATUS, d);
        chk((d >> 4) & 32'hF, 32'(spss_pkg::ST_S5));
        finish_test();
    end
endmodule
`default_nettype wire
